// >>> hw/pfm_port_mux.sv
// The strobed register port was chosen for this implementation.
`include "pfm_defs.svh"
`default_nettype none
module pfm_port_mux (
	input  wire logic             SYS_CLK_IN,
	input  wire logic             RST_N_IN,
	input  wire logic [7:0]       ADDR_IN,
	input  wire logic [7:0]       WDATA_IN,
	input  wire logic             WR_IN,
	input  wire logic             RD_IN,
	input  wire logic             DEBUG_ACTIVE_IN,
	input  wire pfm_pkg::pfm_req_s P0_REQ_IN,
	input  wire pfm_pkg::pfm_req_s P1_REQ_IN,
	output logic [7:0]            RDATA_OUT,
	output pfm_pkg::pfm_pad_s     P0_PAD_OUT,
	output pfm_pkg::pfm_pad_s     P1_PAD_OUT,
	output logic [4:0]            P2_DIR_OUT,
	output logic [2:0]            P2_PERIPH_SEL_OUT,
	output pfm_pkg::pfm_owner_e   P0_OWNER_OUT,
	output pfm_pkg::pfm_owner_e   P1_OWNER_OUT
);
	logic [7:0] p0_inmode_ff, nxt_p0_inmode;
	logic [7:0] p2_func_ff, nxt_p2_func;
	logic [7:0] p1_inmode_ff, nxt_p1_inmode;
	logic [7:0] p0_dir_ff, nxt_p0_dir;
	logic [7:0] p1_dir_ff, nxt_p1_dir;
	logic [7:0] p2_dir_ff, nxt_p2_dir;
	logic [7:0] pull_pol_ff, nxt_pull_pol;
	logic [7:0] location_ff, nxt_location;
	logic [7:0] rdata_ff, nxt_rdata;
	pfm_pkg::pfm_pad_s    p0_pad_ff, nxt_p0_pad;
	pfm_pkg::pfm_pad_s    p1_pad_ff, nxt_p1_pad;
	logic [4:0]           p2_dir_out_ff, nxt_p2_dir_out;
	logic [2:0]           p2_sel_ff, nxt_p2_sel;
	pfm_pkg::pfm_owner_e  p0_owner_ff, nxt_p0_owner;
	pfm_pkg::pfm_owner_e  p1_owner_ff, nxt_p1_owner;
	pfm_pkg::pfm_p0_pri_e p0_pri;
	pfm_pkg::pfm_req_s    p1_eff;
	logic                 ua_b_wins, ua_t1_wins, ub_t3_wins, t1_t4_wins;
	logic                 p0_b_first;
	logic                 p0_a_req, p0_b_req;
	pfm_pkg::pfm_owner_e  p0_a_id, p0_b_id;
	pfm_pkg::pfm_owner_e  p0_own;
	logic [7:0]           p1_pullable;

	// register writes, unused bits masked to zero
	always_comb begin
		nxt_p0_inmode = p0_inmode_ff;
		nxt_p2_func   = p2_func_ff;
		nxt_p1_inmode = p1_inmode_ff;
		nxt_p0_dir    = p0_dir_ff;
		nxt_p1_dir    = p1_dir_ff;
		nxt_p2_dir    = p2_dir_ff;
		nxt_pull_pol  = pull_pol_ff;
		nxt_location  = location_ff;
		if (WR_IN) begin
			unique case (ADDR_IN)
				`PFM_ADDR_P0_INMODE: nxt_p0_inmode = WDATA_IN;
				`PFM_ADDR_P2_FUNC:   nxt_p2_func = WDATA_IN & `PFM_MASK_P2_FUNC;
				`PFM_ADDR_P1_INMODE: nxt_p1_inmode = WDATA_IN & `PFM_MASK_P1_INMODE;
				`PFM_ADDR_P0_DIR:    nxt_p0_dir = WDATA_IN;
				`PFM_ADDR_P1_DIR:    nxt_p1_dir = WDATA_IN;
				`PFM_ADDR_P2_DIR:    nxt_p2_dir = WDATA_IN & `PFM_MASK_P2_DIR;
				`PFM_ADDR_PULL_POL:  nxt_pull_pol = WDATA_IN & `PFM_MASK_PULL_POL;
				`PFM_ADDR_LOCATION:  nxt_location = WDATA_IN & `PFM_MASK_LOCATION;
				default: ;
			endcase
		end
	end

	// read data, valid the cycle after the strobe, unmapped reads zero
	always_comb begin
		nxt_rdata = `PFM_RST_BYTE;
		if (RD_IN) begin
			unique case (ADDR_IN)
				`PFM_ADDR_P0_INMODE: nxt_rdata = p0_inmode_ff;
				`PFM_ADDR_P2_FUNC:   nxt_rdata = p2_func_ff;
				`PFM_ADDR_P1_INMODE: nxt_rdata = p1_inmode_ff;
				`PFM_ADDR_P0_DIR:    nxt_rdata = p0_dir_ff;
				`PFM_ADDR_P1_DIR:    nxt_rdata = p1_dir_ff;
				`PFM_ADDR_P2_DIR:    nxt_rdata = p2_dir_ff;
				`PFM_ADDR_PULL_POL:  nxt_rdata = pull_pol_ff;
				`PFM_ADDR_LOCATION:  nxt_rdata = location_ff;
				default:             nxt_rdata = `PFM_RST_BYTE;
			endcase
		end
	end

	// a unit requests port 1 only when its location bit places it there
	always_comb begin
		p1_eff.ua = P1_REQ_IN.ua & location_ff[`PFM_BIT_LOC_UA];
		p1_eff.ub = P1_REQ_IN.ub & location_ff[`PFM_BIT_LOC_UB];
		p1_eff.t1 = P1_REQ_IN.t1 & location_ff[`PFM_BIT_LOC_T1];
		p1_eff.t3 = P1_REQ_IN.t3 & location_ff[`PFM_BIT_LOC_T3];
		p1_eff.t4 = P1_REQ_IN.t4 & location_ff[`PFM_BIT_LOC_T4];
		p0_pri = pfm_pkg::pfm_p0_pri_e'(p2_dir_ff[`PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_PRI_HI:`PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_PRI_LO]);
	end

	// port-1 pairwise precedence
	pfm_arbiter u_uaub (
		.a_req_in   (p1_eff.ua),
		.b_req_in   (p1_eff.ub),
		.b_first_in (p2_func_ff[`PFM_BIT_P1_UA_UB]),
		.a_id_in    (pfm_pkg::PFM_OWN_UA),
		.b_id_in    (pfm_pkg::PFM_OWN_UB),
		.a_wins_out (ua_b_wins),
		.owner_out  ()
	);
	pfm_arbiter u_ubt3 (
		.a_req_in   (p1_eff.ub),
		.b_req_in   (p1_eff.t3),
		.b_first_in (p2_func_ff[`PFM_BIT_P1_UB_T3]),
		.a_id_in    (pfm_pkg::PFM_OWN_UB),
		.b_id_in    (pfm_pkg::PFM_OWN_T3),
		.a_wins_out (ub_t3_wins),
		.owner_out  ()
	);
	pfm_arbiter u_t1t4 (
		.a_req_in   (p1_eff.t1),
		.b_req_in   (p1_eff.t4),
		.b_first_in (p2_func_ff[`PFM_BIT_P1_T1_T4]),
		.a_id_in    (pfm_pkg::PFM_OWN_T1),
		.b_id_in    (pfm_pkg::PFM_OWN_T4),
		.a_wins_out (t1_t4_wins),
		.owner_out  ()
	);
	pfm_arbiter u_uat1 (
		.a_req_in   (p1_eff.ua),
		.b_req_in   (p1_eff.t1),
		.b_first_in (p2_func_ff[`PFM_BIT_P1_UA_T1]),
		.a_id_in    (pfm_pkg::PFM_OWN_UA),
		.b_id_in    (pfm_pkg::PFM_OWN_T1),
		.a_wins_out (ua_t1_wins),
		.owner_out  ()
	);

	// port-0 pair chosen by the precedence code
	always_comb begin
		unique case (p0_pri)
			pfm_pkg::PFM_P0_UA_OVER_UB: begin
				p0_a_req = P0_REQ_IN.ua;
				p0_b_req = P0_REQ_IN.ub;
				p0_a_id  = pfm_pkg::PFM_OWN_UA;
				p0_b_id  = pfm_pkg::PFM_OWN_UB;
			end
			pfm_pkg::PFM_P0_UB_OVER_UA: begin
				p0_a_req = P0_REQ_IN.ub;
				p0_b_req = P0_REQ_IN.ua;
				p0_a_id  = pfm_pkg::PFM_OWN_UB;
				p0_b_id  = pfm_pkg::PFM_OWN_UA;
			end
			pfm_pkg::PFM_P0_T1LO_OVER_UB: begin
				p0_a_req = P0_REQ_IN.t1;
				p0_b_req = P0_REQ_IN.ub;
				p0_a_id  = pfm_pkg::PFM_OWN_T1;
				p0_b_id  = pfm_pkg::PFM_OWN_UB;
			end
			pfm_pkg::PFM_P0_T1HI_OVER_UA: begin
				p0_a_req = P0_REQ_IN.t1;
				p0_b_req = P0_REQ_IN.ua;
				p0_a_id  = pfm_pkg::PFM_OWN_T1;
				p0_b_id  = pfm_pkg::PFM_OWN_UA;
			end
		endcase
		p0_b_first = 1'b0; // first of the pair always favoured
	end

	pfm_arbiter u_p0 (
		.a_req_in   (p0_a_req),
		.b_req_in   (p0_b_req),
		.b_first_in (p0_b_first),
		.a_id_in    (p0_a_id),
		.b_id_in    (p0_b_id),
		.a_wins_out (),
		.owner_out  (p0_own)
	);

	// pad controls and port-2 selects from the configuration registers
	always_comb begin
		p1_pullable = `PFM_MASK_P1_INMODE;
		nxt_p0_pad.dir       = p0_dir_ff;
		nxt_p0_pad.pull_en   = ~p0_inmode_ff & ~p0_dir_ff;
		nxt_p0_pad.pull_down = {8{pull_pol_ff[`PFM_BIT_PULL_P0]}};
		nxt_p1_pad.dir       = p1_dir_ff;
		nxt_p1_pad.pull_en   = ~p1_inmode_ff & ~p1_dir_ff & p1_pullable;
		nxt_p1_pad.pull_down = {8{pull_pol_ff[`PFM_BIT_PULL_P1]}};
		nxt_p2_dir_out = p2_dir_ff[`PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_HI:0];
		nxt_p2_sel = {p2_func_ff[`PFM_BIT_SEL24], p2_func_ff[`PFM_BIT_SEL23],
			p2_func_ff[`PFM_BIT_SEL20]};
		// debug takes the port-2 function while active, stored bits stay intact
		if (DEBUG_ACTIVE_IN) begin
			nxt_p2_sel = 3'h0;
		end
	end

	// owner of the shared pins on each port
	always_comb begin
		nxt_p0_owner = p0_own;
		// chained pairs: a unit owns the pins only if it wins every clash it is in
		// settings that leave the order inconclusive fall back to the fixed check order
		if (p1_eff.ua && ua_b_wins && ua_t1_wins) begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_UA;
		end else if (p1_eff.ub && !(p1_eff.ua && ua_b_wins) && ub_t3_wins) begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_UB;
		end else if (p1_eff.t1 && !(p1_eff.ua && ua_t1_wins) && t1_t4_wins) begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_T1;
		end else if (p1_eff.t3 && !(p1_eff.ub && ub_t3_wins)) begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_T3;
		end else if (p1_eff.t4 && !(p1_eff.t1 && t1_t4_wins)) begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_T4;
		end else begin
			nxt_p1_owner = pfm_pkg::PFM_OWN_NONE;
		end
	end

	// configuration registers
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			p0_inmode_ff  <= `PFM_RST_BYTE;
			p2_func_ff    <= `PFM_RST_BYTE;
			p1_inmode_ff  <= `PFM_RST_BYTE;
			p0_dir_ff     <= `PFM_RST_BYTE;
			p1_dir_ff     <= `PFM_RST_BYTE;
			p2_dir_ff     <= `PFM_RST_BYTE;
			pull_pol_ff   <= `PFM_RST_BYTE;
			location_ff   <= `PFM_RST_BYTE;
		end else begin
			p0_inmode_ff  <= nxt_p0_inmode;
			p2_func_ff    <= nxt_p2_func;
			p1_inmode_ff  <= nxt_p1_inmode;
			p0_dir_ff     <= nxt_p0_dir;
			p1_dir_ff     <= nxt_p1_dir;
			p2_dir_ff     <= nxt_p2_dir;
			pull_pol_ff   <= nxt_pull_pol;
			location_ff   <= nxt_location;
		end
	end

	// read data, one cycle wide, zero otherwise
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata_ff      <= `PFM_RST_BYTE;
		end else begin
			rdata_ff      <= nxt_rdata;
		end
	end

	// pad and port-2 outputs, one clock behind the registers
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			p0_pad_ff     <= '0;
			p1_pad_ff     <= '0;
			p2_dir_out_ff <= '0;
			p2_sel_ff     <= '0;
		end else begin
			p0_pad_ff     <= nxt_p0_pad;
			p1_pad_ff     <= nxt_p1_pad;
			p2_dir_out_ff <= nxt_p2_dir_out;
			p2_sel_ff     <= nxt_p2_sel;
		end
	end

	// owner outputs
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			p0_owner_ff   <= pfm_pkg::PFM_OWN_NONE;
			p1_owner_ff   <= pfm_pkg::PFM_OWN_NONE;
		end else begin
			p0_owner_ff   <= nxt_p0_owner;
			p1_owner_ff   <= nxt_p1_owner;
		end
	end

	// outputs straight from flops
	assign RDATA_OUT         = rdata_ff;
	assign P0_PAD_OUT        = p0_pad_ff;
	assign P1_PAD_OUT        = p1_pad_ff;
	assign P2_DIR_OUT        = p2_dir_out_ff;
	assign P2_PERIPH_SEL_OUT = p2_sel_ff;
	assign P0_OWNER_OUT      = p0_owner_ff;
	assign P1_OWNER_OUT      = p1_owner_ff;
endmodule // pfm_port_mux
`default_nettype wire

// >>> hw/pfm_defs.svh
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH
// register addresses on the 8-bit special-function bus
`define PFM_ADDR_P0_INMODE   8'h8f
`define PFM_ADDR_P2_FUNC     8'hf5
`define PFM_ADDR_P1_INMODE   8'hf6
`define PFM_ADDR_P0_DIR      8'hfd
`define PFM_ADDR_P1_DIR      8'hfe
`define PFM_ADDR_P2_DIR      8'hff
`define PFM_ADDR_PULL_POL    8'he0
`define PFM_ADDR_LOCATION    8'he1
// writable bit masks, unused bits stay zero
`define PFM_MASK_P2_FUNC     8'h7f
`define PFM_MASK_P1_INMODE   8'hfc
`define PFM_MASK_P2_DIR      8'hdf
`define PFM_MASK_PULL_POL    8'h03
`define PFM_MASK_LOCATION    8'h73
// field positions
`define PFM_BIT_P1_UA_UB     6
`define PFM_BIT_P1_UB_T3     5
`define PFM_BIT_P1_T1_T4     4
`define PFM_BIT_P1_UA_T1     3
`define PFM_BIT_SEL24        2
`define PFM_BIT_SEL23        1
`define PFM_BIT_SEL20        0
`define PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_PRI_HI     7
`define PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_PRI_LO     6
`define PFM_PORT2_DIRECTION_AND_PORT0_PRECEDENCE_HI         4
`define PFM_BIT_LOC_T1       6
`define PFM_BIT_LOC_T3       5
`define PFM_BIT_LOC_T4       4
`define PFM_BIT_LOC_UB       1
`define PFM_BIT_LOC_UA       0
`define PFM_BIT_PULL_P0      0
`define PFM_BIT_PULL_P1      1
// reset values
`define PFM_RST_BYTE         8'h00
`define PFM_RST_BIT          1'b0
`endif

// >>> hw/pfm_pkg.sv
`default_nettype none
package pfm_pkg;
	// port-0 precedence codes
	typedef enum logic [1:0] {
		PFM_P0_UA_OVER_UB,
		PFM_P0_UB_OVER_UA,
		PFM_P0_T1LO_OVER_UB,
		PFM_P0_T1HI_OVER_UA
	} pfm_p0_pri_e;
	// which unit owns a shared pin group
	typedef enum logic [2:0] {
		PFM_OWN_NONE,
		PFM_OWN_UA,
		PFM_OWN_UB,
		PFM_OWN_T1,
		PFM_OWN_T3,
		PFM_OWN_T4
	} pfm_owner_e;
	// peripheral requests for a port
	typedef struct packed {
		logic ua;
		logic ub;
		logic t1;
		logic t3;
		logic t4;
	} pfm_req_s;
	// per-pin pad controls for one 8-bit port
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] pull_en;
		logic [7:0] pull_down;
	} pfm_pad_s;
endpackage : pfm_pkg
`default_nettype wire

// >>> hw/pfm_arbiter.sv
`default_nettype none
// two-way precedence between peripherals that want one pin group
module pfm_arbiter (
	input  wire logic              a_req_in,
	input  wire logic              b_req_in,
	input  wire logic              b_first_in,
	input  wire pfm_pkg::pfm_owner_e a_id_in,
	input  wire pfm_pkg::pfm_owner_e b_id_in,
	output logic                   a_wins_out,
	output pfm_pkg::pfm_owner_e    owner_out
);
	// one request alone always wins, a tie goes to the favoured side
	always_comb begin
		a_wins_out = a_req_in && !(b_req_in && b_first_in);
		if (a_wins_out) begin
			owner_out = a_id_in;
		end else if (b_req_in) begin
			owner_out = b_id_in;
		end else begin
			owner_out = pfm_pkg::PFM_OWN_NONE;
		end
	end
endmodule // pfm_arbiter
`default_nettype wire

// >>> verif/pfm_port_mux_checker.sv
`default_nettype none
// port-level checks on the mux
module pfm_port_mux_checker (
	input wire logic                SYS_CLK_IN,
	input wire logic                RST_N_IN,
	input wire logic [7:0]          ADDR_IN,
	input wire logic [7:0]          WDATA_IN,
	input wire logic                WR_IN,
	input wire logic                RD_IN,
	input wire logic                DEBUG_ACTIVE_IN,
	input wire pfm_pkg::pfm_req_s   P0_REQ_IN,
	input wire pfm_pkg::pfm_req_s   P1_REQ_IN,
	input wire logic [7:0]          RDATA_OUT,
	input wire pfm_pkg::pfm_pad_s   P0_PAD_OUT,
	input wire pfm_pkg::pfm_pad_s   P1_PAD_OUT,
	input wire logic [4:0]          P2_DIR_OUT,
	input wire logic [2:0]          P2_PERIPH_SEL_OUT,
	input wire pfm_pkg::pfm_owner_e P0_OWNER_OUT,
	input wire pfm_pkg::pfm_owner_e P1_OWNER_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// direction writes reach the pads two edges later
	a_p0_dir_write: assert property (WR_IN && ADDR_IN == 8'hfd |->
		##2 P0_PAD_OUT.dir == $past(WDATA_IN, 2)) else $error("port0 direction wrong");
	a_p1_dir_write: assert property (WR_IN && ADDR_IN == 8'hfe |->
		##2 P1_PAD_OUT.dir == $past(WDATA_IN, 2)) else $error("port1 direction wrong");
	a_p2_dir_write: assert property (WR_IN && ADDR_IN == 8'hff |->
		##2 {3'h0, P2_DIR_OUT} == ($past(WDATA_IN, 2) & 8'h1f)) else $error("port2 dir wrong");
	// pulls only on inputs, never on the two low port-1 pins
	a_p0_pull_input: assert property ((P0_PAD_OUT.pull_en & P0_PAD_OUT.dir) == 8'h00)
		else $error("pull on an output pin");
	a_p1_pull_none: assert property (P1_PAD_OUT.pull_en[1:0] == 2'h0)
		else $error("pull on port1 pin 0 or 1");
	// debug forces port-2 pins to plain io
	a_debug_gpio_only: assert property ($past(DEBUG_ACTIVE_IN) |-> P2_PERIPH_SEL_OUT == 3'h0)
		else $error("periph select during debug");
	// unused bits read back as zero
	a_p2func_bit_zero: assert property (RD_IN && ADDR_IN == 8'hf5 |=> !RDATA_OUT[7])
		else $error("function bit 7 not zero");
	a_p1mode_low_zero: assert property (RD_IN && ADDR_IN == 8'hf6 |=> RDATA_OUT[1:0] == 2'h0)
		else $error("input mode bits 1:0 not zero");
	a_port2_direction_and_port0_precedence_bit_zero: assert property (RD_IN && ADDR_IN == 8'hff |=> !RDATA_OUT[5])
		else $error("direction bit 5 not zero");
endmodule // pfm_port_mux_checker
bind pfm_port_mux pfm_port_mux_checker chk_u (.SYS_CLK_IN, .RST_N_IN, .ADDR_IN, .WDATA_IN,
	.WR_IN, .RD_IN, .DEBUG_ACTIVE_IN, .P0_REQ_IN, .P1_REQ_IN, .RDATA_OUT, .P0_PAD_OUT,
	.P1_PAD_OUT, .P2_DIR_OUT, .P2_PERIPH_SEL_OUT, .P0_OWNER_OUT, .P1_OWNER_OUT);
`default_nettype wire

// >>> verif/pfm_pad_load.sv
`default_nettype none
// outside load on port-0 pins: resistor on pulled inputs, a busy driver elsewhere
module pfm_pad_load (
	input wire logic              clk_in,
	input wire pfm_pkg::pfm_pad_s pad_in,
	output logic [7:0]            level_out
);
	logic [7:0] pat_ff = 8'h5a;
	// pattern flips each cycle so no stale level survives
	always_ff @(posedge clk_in) begin
		pat_ff <= ~pat_ff;
	end
	// pull-up when polarity low, pull-down when high
	assign level_out = (pad_in.pull_en & ~pad_in.pull_down) | (~pad_in.pull_en & pat_ff);
endmodule // pfm_pad_load
`default_nettype wire

// >>> verif/port_function_direction_mux_test.sv
`default_nettype none
module port_function_direction_mux_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk, rst_n, wr, rd, dbg;
	logic [7:0]          addr, wdata, rdata, lvl;
	logic [4:0]          port2_direction_and_port0_precedence;
	logic [2:0]          port2_function_and_port1_precedence;
	pfm_pkg::pfm_req_s   req0, req1;
	pfm_pkg::pfm_pad_s   pad0, pad1;
	pfm_pkg::pfm_owner_e own0, own1;
	int                  bad_count, checks, cyc, i, v;
	logic [7:0] ra[9] = '{8'h8f, 8'hf5, 8'hf6, 8'hfd, 8'hfe, 8'hff, 8'he0, 8'he1, 8'h55};
	logic [7:0] rm[9] = '{8'hff, 8'h7f, 8'hfc, 8'hff, 8'hff, 8'hdf, 8'h03, 8'h73, 8'h00};
	pfm_port_mux dut_u (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .DEBUG_ACTIVE_IN(dbg), .P0_REQ_IN(req0), .P1_REQ_IN(req1),
		.RDATA_OUT(rdata), .P0_PAD_OUT(pad0), .P1_PAD_OUT(pad1), .P2_DIR_OUT(port2_direction_and_port0_precedence),
		.P2_PERIPH_SEL_OUT(port2_function_and_port1_precedence), .P0_OWNER_OUT(own0), .P1_OWNER_OUT(own1));
	pfm_pad_load load_u (.clk_in(clk), .pad_in(pad0), .level_out(lvl));
	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	// register then output flop
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	// all ones in, masked values back, pads follow
	task automatic t_regs();
		for (i = 0; i < 9; i++) rd_chk(ra[i], 8'h00);
		for (i = 0; i < 9; i++) wr_reg(ra[i], 8'hff);
		for (i = 0; i < 9; i++) rd_chk(ra[i], rm[i]);
		settle();
		chk(pad0.dir, 8'hff);
		chk(pad1.dir, 8'hff);
		chk({3'h0, port2_direction_and_port0_precedence}, 8'h1f);
		chk({5'h0, port2_function_and_port1_precedence}, 8'h07);
		@(posedge clk) dbg <= 1'b1;
		settle();
		chk({5'h0, port2_function_and_port1_precedence}, 8'h00);
		@(posedge clk) dbg <= 1'b0;
		for (i = 0; i < 8; i++) wr_reg(ra[i], 8'h00);
		$display("test regs done");
	endtask
	// pulls on inputs only, polarity seen at the pins
	task automatic t_pull();
		wr_reg(8'hfd, 8'h0f);
		wr_reg(8'h8f, 8'h30);
		wr_reg(8'he0, 8'h01);
		settle();
		chk(pad0.pull_en, 8'hc0);
		chk(lvl & 8'hc0, 8'h00);
		chk(pad1.pull_en, 8'hfc);
		chk(pad1.pull_down, 8'h00);
		wr_reg(8'he0, 8'h02);
		settle();
		chk(lvl & 8'hc0, 8'hc0);
		chk(pad1.pull_down, 8'hff);
		wr_reg(8'he0, 8'h00);
		wr_reg(8'hfd, 8'h00);
		wr_reg(8'h8f, 8'h00);
		$display("test pull done");
	endtask
	// port-1 pairwise clashes, owner codes 1 ua 2 ub 3 t1 4 t3 5 t4
	task automatic t_p1pri();
		logic [4:0] pat[4] = '{5'h18, 5'h0a, 5'h05, 5'h14};
		int bp[4] = '{6, 5, 4, 3};
		logic [2:0] w0[4] = '{3'h1, 3'h2, 3'h3, 3'h1};
		logic [2:0] w1[4] = '{3'h2, 3'h4, 3'h5, 3'h3};
		wr_reg(8'he1, 8'h73);
		for (i = 0; i < 4; i++) begin
			@(posedge clk) req1 <= pat[i];
			for (v = 0; v < 2; v++) begin
				wr_reg(8'hf5, 8'(v << bp[i]));
				settle();
				chk({5'h0, own1}, {5'h0, (v == 1) ? w1[i] : w0[i]});
			end
		end
		// serial A alone, but placed off port 1: nobody owns the pins
		@(posedge clk) req1 <= 5'h10;
		wr_reg(8'he1, 8'h72);
		settle();
		chk({5'h0, own1}, 8'h00);
		@(posedge clk) req1 <= 5'h00;
		wr_reg(8'hf5, 8'h00);
		$display("test port1 precedence done");
	endtask
	// every port-0 precedence code
	task automatic t_p0pri();
		logic [4:0] pat[4] = '{5'h18, 5'h18, 5'h0c, 5'h14};
		logic [2:0] w[4] = '{3'h1, 3'h2, 3'h3, 3'h3};
		for (i = 0; i < 4; i++) begin
			@(posedge clk) req0 <= pat[i];
			wr_reg(8'hff, 8'(i << 6));
			settle();
			chk({5'h0, own0}, {5'h0, w[i]});
		end
		@(posedge clk) req0 <= 5'h00;
		$display("test port0 precedence done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		{rst_n, wr, rd, dbg, addr, wdata, req0, req1} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_pull();
		t_p1pri();
		t_p0pri();
		wrap_up();
	end
endmodule // port_function_direction_mux_test
`default_nettype wire
